// *** src/osc_pkg.sv ***
package osc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_VSB  = 8'h00;
   localparam logic [7:0] OFF_HTC  = 8'h04;
   localparam logic [7:0] OFF_FLD  = 8'h08;
   localparam logic [7:0] OFF_PAL0 = 8'h0c;
   localparam logic [7:0] OFF_SCC  = 8'h24;
   localparam logic [7:0] OFF_DSP  = 8'h28;
   localparam logic [7:0] OFF_RSC  = 8'h2c;
   localparam logic [7:0] OFF_CSZ  = 8'h30;
   localparam logic [7:0] OFF_CBF  = 8'h34;
   localparam logic [7:0] OFF_BGC  = 8'h38;
   localparam logic [7:0] OFF_CWR  = 8'h3c;
   // Value of every register after reset
   localparam logic [7:0] REG_RST  = 8'h00;
   // Halftone control fields
   localparam int HTC_VIRQ_EN   = 0;
   localparam int HTC_VIRQ_PEND = 1;
   localparam int HTC_FRAME     = 2;
   localparam int HTC_BG_EN     = 3;
   localparam int HTC_RIRQ_EN   = 4;
   localparam int HTC_RIRQ_PEND = 5;
   localparam int HTC_RGB_INV   = 6;
   localparam int HTC_HT_INV    = 7;
   // Field detect fields
   localparam int FLD_AFTER = 4;
   localparam int FLD_EVEN  = 5;
   // Space colour fields
   localparam int SCC_ANALOG  = 0;
   localparam int SCC_SP_HT   = 1;
   localparam int SCC_SP_COL  = 2;
   localparam int SCC_HALF_FR = 3;
   // Line and row counts
   localparam logic [4:0] VSB_FLOOR   = 5'h09;
   localparam logic [3:0] ROW_COUNT   = 4'hc;
   localparam logic [9:0] TOP_UNIT    = 10'h004;
   localparam logic [9:0] CHAR_LINES  = 10'h012;
   // Character word layout
   localparam int WORD_HT_BIT = 13;
   localparam int WORD_DW     = 14;
   localparam int RAM_DEPTH   = 252;
endpackage

// *** src/osc_char_ram.sv ***
`timescale 1ns/1ps
// Character word store, registered read port
module osc_char_ram #(
   parameter int DEPTH = 252,
   parameter int AW    = 8,
   parameter int DW    = 14
)(
   input  wire logic          ref_clk_in,
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem [DEPTH];

   // Write port and registered read
   always_ff @(posedge ref_clk_in)
   begin
      if (wr_en_in && (int'(wr_addr_in) < DEPTH))
         mem[wr_addr_in] <= wr_data_in;
      rd_data_out <= (int'(rd_addr_in) < DEPTH) ? mem[rd_addr_in] : '0;
   end
endmodule

// *** src/osc_overlay_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Stop dot oscillator programmed lines after vsync
// - Blank counts zero to nine give nine lines
// - One interrupt per displayed row, twelve max
// - Row counter in display control upper nibble
// - Fewer rows when layout leaves the frame
// - Row writes apply from the next row
// - Enable immediate; margin, blank latched at vsync
// - Character halftone from stored bit, mode 1x
// - Frame halftone ignores stored character bit
// - Halftone register holds row and vsync interrupts
// - Even field when hsync falls in window
// - Window before or after vsync selectable
// - Field result readable in field bit five
// - Two palette registers per channel, mode pairs
// - Codes 00 off, 01 third, 10 two thirds
// - Digital mode: two levels, palette ignored
// - Analog mode: palette levels, mode per character
// - Space halftone follows background bit three
// - Bit three enables background halftone always
// - Space halftone on frame needs bits three, two
// - Space colour from character or frame background
// - Space bit three selects half-dot fringe
// - Character word carries colour and bit 13
module osc_overlay_ctrl #(
   parameter int FRAME_LINES    = 262,
   parameter int FIELD_UNIT_CYC = 16
)(
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        vsync_in,
   input  wire logic        hsync_in,
   input  wire logic        char_period_in,
   input  wire logic        char_bg_period_in,
   input  wire logic        frame_period_in,
   input  wire logic        space_period_in,
   input  wire logic [7:0]  char_addr_in,
   output logic             osc_stop_out,
   output logic             row_irq_out,
   output logic             vsync_irq_out,
   output logic             halftone_out,
   output logic      [1:0]  red_out,
   output logic      [1:0]  green_out,
   output logic      [1:0]  blue_out,
   output logic      [9:0]  char_code_out,
   output logic      [1:0]  row_size_out,
   output logic      [2:0]  row_space_out,
   output logic             fringe_half_dot_out
);
   logic [7:0]  vsb, htc, fld, scc, dsp, rsc, csz, cbf, bgc;
   logic [7:0]  pal [6];
   logic [3:0]  row_cnt;
   logic [2:0]  vs_sync, hs_sync;
   logic        vs_lvl, hs_lvl;
   logic [9:0]  line_cnt, row_line;
   logic [4:0]  blank_eff;
   logic [3:0]  row_idx;
   logic [15:0] since_h, win_cnt;
   logic        win_hit;
   logic [13:0] cur_word;
   logic [7:0]  rd_mux;

   // Bus decode
   wire        req     = wb_cyc_in & wb_stb_in;
   wire        wr      = req & wb_we_in & wb_ack_out & wb_sel_in[0];
   wire [5:0]  widx    = wb_adr_in[7:2];
   wire [7:0]  wd      = wb_dat_in[7:0];
   wire        wr_vsb  = wr & (widx == osc_pkg::OFF_VSB[7:2]);
   wire        wr_htc  = wr & (widx == osc_pkg::OFF_HTC[7:2]);
   wire        wr_fld  = wr & (widx == osc_pkg::OFF_FLD[7:2]);
   wire        wr_scc  = wr & (widx == osc_pkg::OFF_SCC[7:2]);
   wire        wr_dsp  = wr & (widx == osc_pkg::OFF_DSP[7:2]);
   wire        wr_rsc  = wr & (widx == osc_pkg::OFF_RSC[7:2]);
   wire        wr_csz  = wr & (widx == osc_pkg::OFF_CSZ[7:2]);
   wire        wr_cbf  = wr & (widx == osc_pkg::OFF_CBF[7:2]);
   wire        wr_bgc  = wr & (widx == osc_pkg::OFF_BGC[7:2]);
   wire        wr_cwr  = wr & (widx == osc_pkg::OFF_CWR[7:2]) & (&wb_sel_in[2:0]);

   // Sync pin edges, valid once second and third stages agree
   wire        vs_new  = (vs_sync[1] == vs_sync[2]) ? vs_sync[2] : vs_lvl;
   wire        hs_new  = (hs_sync[1] == hs_sync[2]) ? hs_sync[2] : hs_lvl;
   wire        v_edge  = vs_new & ~vs_lvl;
   wire        h_edge  = hs_new & ~hs_lvl;

   // Line and row timing terms
   wire [4:0]  blank_new = (vsb[4:0] <= osc_pkg::VSB_FLOOR) ? osc_pkg::VSB_FLOOR : vsb[4:0];
   wire [9:0]  top_lines = 10'(osc_pkg::TOP_UNIT * {5'h00, rsc[7:3]});
   wire [9:0]  row_lines = 10'(osc_pkg::CHAR_LINES * ({8'h00, csz[7:6]} + 10'h001));
   wire [9:0]  line_nxt  = line_cnt + 10'h001;
   wire        row_hit   = h_edge & (line_nxt == row_line) & (row_idx < osc_pkg::ROW_COUNT)
                           & (int'(row_line) < FRAME_LINES);
   wire [15:0] win_cyc   = 16'(int'(fld[3:0]) * FIELD_UNIT_CYC);

   // Halftone terms
   wire        ht_char   = ~htc[osc_pkg::HTC_FRAME] & char_period_in
                           & cur_word[osc_pkg::WORD_HT_BIT] & dsp[2];
   wire        ht_frame  = htc[osc_pkg::HTC_FRAME] & frame_period_in;
   wire        ht_bg     = htc[osc_pkg::HTC_BG_EN] & char_bg_period_in;
   wire        ht_space  = space_period_in & (scc[osc_pkg::SCC_SP_HT]
                           ? (htc[osc_pkg::HTC_BG_EN] & htc[osc_pkg::HTC_FRAME])
                           : htc[osc_pkg::HTC_BG_EN]);
   wire        ht_raw    = dsp[0] & (ht_char | ht_frame | ht_bg | ht_space);

   // Colour mode of the current dot
   wire [2:0]  space_mode = scc[osc_pkg::SCC_SP_COL] ? bgc[5:3] : bgc[2:0];
   wire [2:0]  cur_mode   = space_period_in ? space_mode : cur_word[12:10];

   // Outputs taken straight from state
   assign osc_stop_out        = line_cnt < {5'h00, blank_eff};
   assign row_irq_out         = htc[osc_pkg::HTC_RIRQ_EN] & htc[osc_pkg::HTC_RIRQ_PEND];
   assign vsync_irq_out       = htc[osc_pkg::HTC_VIRQ_EN] & htc[osc_pkg::HTC_VIRQ_PEND];
   assign fringe_half_dot_out = scc[osc_pkg::SCC_HALF_FR];
   assign char_code_out       = cur_word[9:0];

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      rd_mux = 8'h00;
      case (widx)
         osc_pkg::OFF_VSB[7:2]: rd_mux = vsb;
         osc_pkg::OFF_HTC[7:2]: rd_mux = htc;
         osc_pkg::OFF_FLD[7:2]: rd_mux = fld;
         osc_pkg::OFF_SCC[7:2]: rd_mux = scc;
         osc_pkg::OFF_DSP[7:2]: rd_mux = {row_cnt, dsp[3:0]};
         osc_pkg::OFF_RSC[7:2]: rd_mux = rsc;
         osc_pkg::OFF_CSZ[7:2]: rd_mux = csz;
         osc_pkg::OFF_CBF[7:2]: rd_mux = cbf;
         osc_pkg::OFF_BGC[7:2]: rd_mux = bgc;
         default:
         begin
            if (widx >= osc_pkg::OFF_PAL0[7:2] && widx < osc_pkg::OFF_SCC[7:2])
               rd_mux = pal[3'(widx - osc_pkg::OFF_PAL0[7:2])];
         end
      endcase
   end

   // Wishbone answer one cycle after the request
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_out <= req & ~wb_ack_out;
         wb_dat_out <= {24'h00_0000, rd_mux};
      end
   end

   // Plain software registers
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         {vsb, scc, dsp, rsc, csz, cbf, bgc} <= {7{osc_pkg::REG_RST}};
      end
      else
      begin
         if (wr_vsb) vsb <= wd;
         if (wr_scc) scc <= wd;
         if (wr_dsp) dsp <= {4'h0, wd[3:0]};
         if (wr_rsc) rsc <= wd;
         if (wr_csz) csz <= wd;
         if (wr_cbf) cbf <= {4'h0, wd[3:0]};
         if (wr_bgc) bgc <= {2'h0, wd[5:0]};
      end
   end

   // Palette registers, one per channel half
   for (genvar p = 0; p < 6; p++)
   begin : g_pal
      always_ff @(posedge ref_clk_in)
      begin
         if (reset_in)
            pal[p] <= osc_pkg::REG_RST;
         else if (wr && widx == osc_pkg::OFF_PAL0[7:2] + 6'(p))
            pal[p] <= wd;
      end
   end

   // Halftone control; pending bits cleared by writing zero, set wins
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         htc <= osc_pkg::REG_RST;
      else
      begin
         if (wr_htc)
            htc <= wd;
         htc[osc_pkg::HTC_VIRQ_PEND] <= v_edge | (htc[osc_pkg::HTC_VIRQ_PEND]
                                        & ~(wr_htc & ~wd[osc_pkg::HTC_VIRQ_PEND]));
         htc[osc_pkg::HTC_RIRQ_PEND] <= (row_hit & htc[osc_pkg::HTC_RIRQ_EN])
                                        | (htc[osc_pkg::HTC_RIRQ_PEND]
                                        & ~(wr_htc & ~wd[osc_pkg::HTC_RIRQ_PEND]));
      end
   end

   // Pin synchronisers and filtered levels
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         vs_sync <= 3'h0;
         hs_sync <= 3'h0;
         vs_lvl  <= 1'b0;
         hs_lvl  <= 1'b0;
      end
      else
      begin
         vs_sync <= {vs_sync[1:0], vsync_in};
         hs_sync <= {hs_sync[1:0], hsync_in};
         vs_lvl  <= vs_new;
         hs_lvl  <= hs_new;
      end
   end

   // Line counter, blank latch and row sequencer
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         line_cnt      <= 10'h000;
         blank_eff     <= osc_pkg::VSB_FLOOR;
         row_line      <= 10'h3ff;
         row_idx       <= osc_pkg::ROW_COUNT;
         row_cnt       <= 4'h0;
         row_size_out  <= 2'h0;
         row_space_out <= 3'h0;
      end
      else if (v_edge)
      begin
         line_cnt  <= 10'h000;
         blank_eff <= blank_new;
         row_line  <= {5'h00, blank_new} + top_lines;
         row_idx   <= 4'h0;
      end
      else if (h_edge)
      begin
         if (line_cnt != 10'h3ff)
            line_cnt <= line_nxt;
         if (row_hit)
         begin
            row_cnt       <= row_idx;
            row_idx       <= row_idx + 4'h1;
            row_line      <= row_line + row_lines + {7'h00, rsc[2:0]};
            row_size_out  <= csz[7:6];
            row_space_out <= rsc[2:0];
         end
      end
   end

   // Field detection around the vsync edge
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         fld     <= osc_pkg::REG_RST;
         since_h <= 16'hffff;
         win_cnt <= 16'h0000;
         win_hit <= 1'b0;
      end
      else
      begin
         if (wr_fld)
            fld[4:0] <= wd[4:0];
         if (h_edge)
            since_h <= 16'h0000;
         else if (since_h != 16'hffff)
            since_h <= since_h + 16'h0001;
         if (v_edge && !fld[osc_pkg::FLD_AFTER])
            fld[osc_pkg::FLD_EVEN] <= since_h < win_cyc;
         if (v_edge && fld[osc_pkg::FLD_AFTER])
         begin
            win_cnt <= win_cyc;
            win_hit <= 1'b0;
            if (win_cyc == 16'h0000)
               fld[osc_pkg::FLD_EVEN] <= 1'b0;
         end
         else if (win_cnt != 16'h0000)
         begin
            win_cnt <= win_cnt - 16'h0001;
            win_hit <= win_hit | h_edge;
            if (win_cnt == 16'h0001)
               fld[osc_pkg::FLD_EVEN] <= win_hit | h_edge;
         end
      end
   end

   // Character word store
   osc_char_ram #(
      .DEPTH (osc_pkg::RAM_DEPTH),
      .AW    (8),
      .DW    (osc_pkg::WORD_DW)
   ) u_ram (
      .ref_clk_in  (ref_clk_in),
      .wr_en_in    (wr_cwr),
      .wr_addr_in  (wb_dat_in[7:0]),
      .wr_data_in  ({cbf[3:0], wb_dat_in[17:8]}),
      .rd_addr_in  (char_addr_in),
      .rd_data_out (cur_word)
   );

   // Halftone output with polarity
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         halftone_out <= 1'b0;
      else
         halftone_out <= ht_raw ^ htc[osc_pkg::HTC_HT_INV];
   end

   // Per channel level: palette in analog mode, two levels in digital mode
   logic [1:0] lvl_q [3];
   for (genvar c = 0; c < 3; c++)
   begin : g_chan
      wire [7:0] sel_pal = cur_mode[2] ? pal[2*c+1] : pal[2*c];
      wire [1:0] pal_lvl = sel_pal[{cur_mode[1:0], 1'b0} +: 2];
      wire [1:0] dig_lvl = {2{cur_mode[2-c]}};
      wire [1:0] lvl     = scc[osc_pkg::SCC_ANALOG] ? pal_lvl : dig_lvl;
      always_ff @(posedge ref_clk_in)
      begin
         if (reset_in)
            lvl_q[c] <= 2'h0;
         else
            lvl_q[c] <= dsp[0] ? (lvl ^ {2{htc[osc_pkg::HTC_RGB_INV]}}) : 2'h0;
      end
   end
   assign red_out   = lvl_q[0];
   assign green_out = lvl_q[1];
   assign blue_out  = lvl_q[2];

   // Checks
   property p_ack;
      @(posedge ref_clk_in) disable iff (reset_in) req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_stop;
      @(posedge ref_clk_in) disable iff (reset_in) v_edge |=> osc_stop_out [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("oscillator ran during blank");
   property p_blank_floor;
      @(posedge ref_clk_in) disable iff (reset_in) v_edge && vsb[4:0] <= 5'h09 |=> blank_eff == 5'h09;
   endproperty
   a_blank_floor: assert property (p_blank_floor) else $error("blank floor wrong");
   property p_row_pend;
      @(posedge ref_clk_in) disable iff (reset_in) row_hit && htc[4] |=> row_irq_out;
   endproperty
   a_row_pend: assert property (p_row_pend) else $error("row interrupt missing");
   property p_row_cnt;
      @(posedge ref_clk_in) disable iff (reset_in) row_hit |=> row_cnt == $past(row_idx) && row_cnt < 4'hc;
   endproperty
   a_row_cnt: assert property (p_row_cnt) else $error("row counter wrong");
   property p_row_limit;
      @(posedge ref_clk_in) disable iff (reset_in) h_edge && int'(row_line) >= FRAME_LINES |=> $stable(row_cnt);
   endproperty
   a_row_limit: assert property (p_row_limit) else $error("row outside frame");
   property p_shadow;
      @(posedge ref_clk_in) disable iff (reset_in) !row_hit && !reset_in ##1 !row_hit |-> $stable(row_size_out);
   endproperty
   a_shadow: assert property (p_shadow) else $error("row size changed mid row");
   property p_frame_ht;
      @(posedge ref_clk_in) disable iff (reset_in)
         dsp[0] && htc[2] && frame_period_in |=> halftone_out != $past(htc[7]);
   endproperty
   a_frame_ht: assert property (p_frame_ht) else $error("frame halftone missing");
   property p_digital;
      @(posedge ref_clk_in) disable iff (reset_in) !scc[0] |=> red_out == 2'h0 || red_out == 2'h3;
   endproperty
   a_digital: assert property (p_digital) else $error("digital level wrong");
   property p_field_before;
      @(posedge ref_clk_in) disable iff (reset_in)
         v_edge && !fld[4] |=> fld[5] == ($past(since_h) < $past(win_cyc));
   endproperty
   a_field_before: assert property (p_field_before) else $error("field result wrong");
   c_row: cover property (@(posedge ref_clk_in) disable iff (reset_in) row_hit && row_idx == 4'hb);
   c_even: cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(fld[5]));
   c_analog: cover property (@(posedge ref_clk_in) disable iff (reset_in) scc[0] && red_out == 2'h1);
endmodule

// *** testbench/osc_video_source.sv ***
`timescale 1ns/1ps
// Sync source: hsync every line, vsync phase alternates between fields
module osc_video_source #(
   parameter int LINE_CYC = 32,
   parameter int LINES    = 52
)(
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   output logic            hsync_out,
   output logic            vsync_out,
   output logic            field_near_out,
   output logic      [7:0] line_out
);
   int cyc;
   int off;
   // Dot position, line count and field phase
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         cyc <= 0;
         line_out <= 8'h01;
         field_near_out <= 1'b0;
      end
      else if (cyc < LINE_CYC - 1)
         cyc <= cyc + 1;
      else
      begin
         cyc <= 0;
         line_out <= (line_out == 8'(LINES - 1)) ? 8'h00 : line_out + 8'h01;
         field_near_out <= field_near_out ^ (line_out == 8'(LINES - 1));
      end
   end
   // Near field puts vsync just after hsync, far field mid-line
   assign off       = field_near_out ? 4 : 20;
   assign hsync_out = (cyc < 4);
   assign vsync_out = (line_out == 8'h00) && (cyc >= off) && (cyc < off + 4);
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
// Self-checking bench for the overlay controller
module testbench;
   logic        ref_clk_in, reset_in, cyc, stb, we, ack;
   logic        vsync, hsync, near, stop, rirq, virq, ht, fhalf;
   logic [7:0]  adr, caddr, vline;
   logic [3:0]  sel, per;
   logic [31:0] wdat, rdat, dout;
   logic [1:0]  red, green, blue, rsize;
   logic [2:0]  rspace;
   logic [9:0]  code;
   int          failures, total_checks;
   logic [7:0]  pal [6] = '{8'he4, 8'h1b, 8'h39, 8'hc6, 8'h93, 8'h6c};

   // Design with a short frame and a short field unit
   osc_overlay_ctrl #(.FRAME_LINES(30), .FIELD_UNIT_CYC(4)) dut (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dout),
      .wb_ack_out(ack), .vsync_in(vsync), .hsync_in(hsync), .char_period_in(per[3]),
      .char_bg_period_in(per[2]), .frame_period_in(per[1]), .space_period_in(per[0]),
      .char_addr_in(caddr), .osc_stop_out(stop), .row_irq_out(rirq), .vsync_irq_out(virq),
      .halftone_out(ht), .red_out(red), .green_out(green), .blue_out(blue),
      .char_code_out(code), .row_size_out(rsize), .row_space_out(rspace), .fringe_half_dot_out(fhalf)
   );

   // Video sync source
   osc_video_source #(.LINE_CYC(32), .LINES(52)) src (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .hsync_out(hsync), .vsync_out(vsync),
      .field_near_out(near), .line_out(vline)
   );

   // Clock
   initial
   begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic hang(input string what);
      failures++;
      $display("mismatch %s expected response seen timeout", what);
      tally_and_finish();
   endtask

   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge ref_clk_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_in);
         if (ack === 1'b1)
            break;
      end
      rdat = dout;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (i == 50)
         hang("bus ack");
   endtask

   // Wait for the start of a fresh line n, then let syncs settle
   task automatic wait_line(input logic [7:0] n);
      int i;
      for (i = 0; i < 4000 && vline === n; i++)
         @(posedge ref_clk_in);
      for (i = 0; i < 4000 && vline !== n; i++)
         @(posedge ref_clk_in);
      if (i == 4000)
         hang("line count");
      repeat (12) @(posedge ref_clk_in);
   endtask

   function automatic logic [5:0] lvl(input int m, input logic analog);
      logic [5:0] e;
      for (int c = 0; c < 3; c++)
         e[5-2*c -: 2] = analog ? 2'(pal[2*c + m/4] >> (2 * (m % 4))) : {2{m[2-c]}};
      return e;
   endfunction

   task automatic t_regs();
      check("stop after reset", stop, 1);
      for (int a = 0; a <= 8'h24; a += 4)
      begin
         wb(0, 8'(a), 0, 4'hf);
         check($sformatf("reset value %h", a), rdat, 32'(osc_pkg::REG_RST));
      end
      wb(0, 8'hfc, 0, 4'hf);
      check("unmapped read", rdat, 0);
      wb(1, osc_pkg::OFF_PAL0, 32'ha5, 4'h0);
      wb(0, osc_pkg::OFF_PAL0, 0, 4'hf);
      check("lane 0 off write", rdat, 0);
      wb(1, osc_pkg::OFF_PAL0, 32'ha5, 4'hf);
      wb(0, osc_pkg::OFF_PAL0, 0, 4'hf);
      check("palette readback", rdat, 32'ha5);
      wb(1, osc_pkg::OFF_HTC, 32'hff, 4'hf);
      wb(0, osc_pkg::OFF_HTC, 0, 4'hf);
      check("halftone ctl readback", rdat, 32'hdd);
      wb(1, osc_pkg::OFF_HTC, 0, 4'hf);
      wb(1, osc_pkg::OFF_SCC, 32'h08, 4'hf);
      repeat (2) @(posedge ref_clk_in);
      check("half dot fringe", fhalf, 1);
      $display("register test done");
   endtask

   task automatic t_blank();
      logic [7:0] pr [3] = '{8'd31, 8'd5, 8'd10};
      logic [7:0] ln [3] = '{8'd31, 8'd9, 8'd10};
      wb(1, osc_pkg::OFF_HTC, 32'h01, 4'hf);
      for (int k = 0; k < 3; k++)
      begin
         wb(1, osc_pkg::OFF_VSB, 32'(pr[k]), 4'hf);
         wait_line(8'd0);
         wait_line(ln[k] - 8'd1);
         check("stop in blank", stop, 1);
         check("vsync irq", virq, 1);
         wait_line(ln[k]);
         check("stop after blank", stop, 0);
      end
      wb(1, osc_pkg::OFF_HTC, 32'h01, 4'hf);
      repeat (2) @(posedge ref_clk_in);
      check("vsync irq cleared", virq, 0);
      $display("blanking test done");
   endtask

   task automatic t_rows();
      logic [7:0] rl [2] = '{8'd9, 8'd27};
      wb(1, osc_pkg::OFF_VSB, 0, 4'hf);
      wb(1, osc_pkg::OFF_CWR, 32'h0, 4'hf);
      wb(1, osc_pkg::OFF_HTC, 32'h10, 4'hf);
      wb(1, osc_pkg::OFF_DSP, 32'h01, 4'hf);
      wait_line(8'd0);
      wb(1, osc_pkg::OFF_HTC, 32'h10, 4'hf);
      wait_line(8'd8);
      check("row irq early", rirq, 0);
      for (int k = 0; k < 2; k++)
      begin
         wait_line(rl[k]);
         check("row irq", rirq, 1);
         wb(0, osc_pkg::OFF_DSP, 0, 4'hf);
         check("row counter", 32'(rdat[7:4]), k);
         check("row space shadow", rspace, 3 * k);
         check("row size shadow", rsize, k);
         wb(1, osc_pkg::OFF_HTC, 32'h10, 4'hf);
         wb(1, osc_pkg::OFF_RSC, 32'h03, 4'hf);
         wb(1, osc_pkg::OFF_CSZ, 32'h40, 4'hf);
         check("row irq cleared", rirq, 0);
      end
      wait_line(8'd48);
      check("row irq past frame", rirq, 0);
      wb(1, osc_pkg::OFF_RSC, 0, 4'hf);
      wb(1, osc_pkg::OFF_CSZ, 0, 4'hf);
      wb(1, osc_pkg::OFF_HTC, 0, 4'hf);
      $display("row test done");
   endtask

   task automatic t_color();
      for (int i = 0; i < 6; i++)
         wb(1, osc_pkg::OFF_PAL0 + 8'(4 * i), 32'(pal[i]), 4'hf);
      for (int m = 0; m < 8; m++)
      begin
         wb(1, osc_pkg::OFF_CBF, 32'({m[0], m[2:0]}), 4'hf);
         wb(1, osc_pkg::OFF_CWR, {14'h0, 7'h55, m[2:0], 5'h0, m[2:0]}, 4'hf);
      end
      wb(1, osc_pkg::OFF_DSP, 32'h01, 4'hf);
      for (int d = 1; d >= 0; d--)
      begin
         wb(1, osc_pkg::OFF_SCC, 32'(d), 4'hf);
         wait_line(8'd0);
         wait_line(8'd10);
         per <= 4'h8;
         for (int m = 0; m < 8; m++)
         begin
            caddr <= 8'(m);
            repeat (4) @(posedge ref_clk_in);
            check("char code", code, {7'h55, m[2:0]});
            check("rgb level", {red, green, blue}, lvl(m, d[0]));
         end
      end
      wb(1, osc_pkg::OFF_BGC, 32'h2c, 4'hf);
      per <= 4'h1;
      repeat (3) @(posedge ref_clk_in);
      check("space colour char bg", {red, green, blue}, lvl(4, 1'b0));
      wb(1, osc_pkg::OFF_SCC, 32'h04, 4'hf);
      repeat (2) @(posedge ref_clk_in);
      check("space colour frame bg", {red, green, blue}, lvl(5, 1'b0));
      wb(1, osc_pkg::OFF_DSP, 0, 4'hf);
      repeat (3) @(posedge ref_clk_in);
      check("rgb after disable", {red, green, blue}, 0);
      per <= 4'h0;
      $display("colour test done");
   endtask

   task automatic t_halftone();
      logic [29:0] t [10] = '{
         {8'h05, 8'h00, 8'h00, 4'h8, 2'b11}, {8'h05, 8'h00, 8'h00, 4'h8, 2'b00},
         {8'h03, 8'h00, 8'h00, 4'h8, 2'b10}, {8'h07, 8'h00, 8'h00, 4'h8, 2'b11},
         {8'h01, 8'h04, 8'h00, 4'h2, 2'b01}, {8'h01, 8'h08, 8'h00, 4'h4, 2'b01},
         {8'h01, 8'h08, 8'h00, 4'h1, 2'b01}, {8'h01, 8'h08, 8'h02, 4'h1, 2'b00},
         {8'h01, 8'h0c, 8'h02, 4'h1, 2'b01}, {8'h05, 8'h80, 8'h00, 4'h8, 2'b01}};
      for (int k = 0; k < 10; k++)
      begin
         wb(1, osc_pkg::OFF_DSP, 32'(t[k][29:22]), 4'hf);
         wb(1, osc_pkg::OFF_HTC, 32'(t[k][21:14]), 4'hf);
         wb(1, osc_pkg::OFF_SCC, 32'(t[k][13:6]), 4'hf);
         wait_line(8'd0);
         wait_line(8'd10);
         per <= t[k][5:2];
         caddr <= {7'h0, t[k][1]};
         repeat (4) @(posedge ref_clk_in);
         check($sformatf("halftone case %0d", k), ht, t[k][0]);
         per <= 4'h0;
      end
      $display("halftone test done");
   endtask

   task automatic t_field();
      logic [7:0] fs [3] = '{8'h03, 8'h14, 8'h00};
      for (int k = 0; k < 3; k++)
      begin
         wb(1, osc_pkg::OFF_FLD, 32'(fs[k]), 4'hf);
         for (int f = 0; f < 2; f++)
         begin
            wait_line(8'd0);
            wait_line(8'd2);
            wb(0, osc_pkg::OFF_FLD, 0, 4'hf);
            check("even field", rdat[5], (k == 0) ? near : (k == 1) ? !near : 1'b0);
         end
      end
      $display("field test done");
   endtask

   // Main sequence
   initial
   begin
      failures = 0;
      total_checks = 0;
      reset_in = 1'b1;
      {cyc, stb, we, adr, sel, wdat, per, caddr} = '0;
      repeat (20) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_blank();
      t_rows();
      t_color();
      t_halftone();
      t_field();
      tally_and_finish();
   end
endmodule
